// ### fcs_defines.vh
`ifndef FCS_DEFINES_VH
`define FCS_DEFINES_VH
`define FCS_OFF_STAT 8'h00
`define FCS_OFF_DATA 8'h04
`define FCS_OFF_CTRL 8'h08
`define FCS_OFF_TIME 8'h0C
`define FCS_OFF_PRECOMP 8'h10
`define FCS_OFF_CFG 8'h14
`define FCS_OFF_MODE 8'h18
`define FCS_ST_RQM 0
`define FCS_ST_DIO 1
`define FCS_ST_BUSY 2
`define FCS_ST_EXEC 3
`define FCS_ST_DRQ 4
`define FCS_OPC_CFG 8'h13
`define FCS_OPC_DUMP 8'h0E
`define FCS_OPC_MODE 8'h01
`define FCS_OPC_IDENT 8'h18
`define FCS_OPC_PERP 8'h12
`define FCS_OPC_LOCK 7'h14
`define FCS_OPC_FMT 7'h0D
`define FCS_OPC_RDID 7'h0A
`define FCS_OPC_RDAT 5'h06
`define FCS_OPC_RDEL 5'h0C
`define FCS_CMD_CFG 0
`define FCS_CMD_DUMP 1
`define FCS_CMD_FMT 2
`define FCS_CMD_LOCK 3
`define FCS_CMD_MODE 4
`define FCS_CMD_IDENT 5
`define FCS_CMD_PERP 6
`define FCS_CMD_RDAT 7
`define FCS_CMD_RDEL 8
`define FCS_CMD_RDID 9
`define FCS_CMD_INV 10
`define FCS_NP_CFG 4'h3
`define FCS_NP_FMT 4'h5
`define FCS_NP_MODE 4'h4
`define FCS_NP_PERP 4'h1
`define FCS_NP_READ 4'h8
`define FCS_NP_RDID 4'h1
`define FCS_NR_DUMP 4'hA
`define FCS_NR_STAT 4'h7
`define FCS_NR_ONE 4'h1
`define FCS_INVALID_ST0 8'h80
// arbitrary identification value
`define FCS_IDENT_BYTE 8'h5A
`endif

// ### fcs_cmd_decode.v
`timescale 1ns/1ns
`include "fcs_defines.vh"
module fcs_cmd_decode (
  input wire [7:0] opcode, // first command byte
  output reg [10:0] cmdSel, // one-hot command
  output reg [3:0] paramCount // bytes that follow the opcode
);
  always @* begin
    cmdSel = 11'h000;
    paramCount = 4'h0;
    if (opcode == `FCS_OPC_CFG) begin
      cmdSel[`FCS_CMD_CFG] = 1'b1;
      paramCount = `FCS_NP_CFG;
    end else if (opcode == `FCS_OPC_DUMP) begin
      cmdSel[`FCS_CMD_DUMP] = 1'b1;
    end else if (opcode == `FCS_OPC_MODE) begin
      cmdSel[`FCS_CMD_MODE] = 1'b1;
      paramCount = `FCS_NP_MODE;
    end else if (opcode == `FCS_OPC_IDENT) begin
      cmdSel[`FCS_CMD_IDENT] = 1'b1;
    end else if (opcode == `FCS_OPC_PERP) begin
      cmdSel[`FCS_CMD_PERP] = 1'b1;
      paramCount = `FCS_NP_PERP;
    end else if (opcode[6:0] == `FCS_OPC_LOCK) begin
      cmdSel[`FCS_CMD_LOCK] = 1'b1;
    end else if ({opcode[7], opcode[5:0]} == `FCS_OPC_FMT) begin
      cmdSel[`FCS_CMD_FMT] = 1'b1;
      paramCount = `FCS_NP_FMT;
    end else if ({opcode[7], opcode[5:0]} == `FCS_OPC_RDID) begin
      cmdSel[`FCS_CMD_RDID] = 1'b1;
      paramCount = `FCS_NP_RDID;
    end else if (opcode[4:0] == `FCS_OPC_RDAT) begin
      cmdSel[`FCS_CMD_RDAT] = 1'b1;
      paramCount = `FCS_NP_READ;
    end else if (opcode[4:0] == `FCS_OPC_RDEL) begin
      cmdSel[`FCS_CMD_RDEL] = 1'b1;
      paramCount = `FCS_NP_READ;
    end else begin
      cmdSel[`FCS_CMD_INV] = 1'b1;
    end
  end
endmodule // fcs_cmd_decode

// ### fcs_result_queue.v
`timescale 1ns/1ns
module fcs_result_queue #(
  parameter DEPTH = 10,
  parameter W = 8
) (
  input wire core_clk, // controller clock
  input wire arst_n, // async reset, active low
  input wire load, // replace contents with loadBytes
  input wire [3:0] loadCount, // number of valid bytes
  input wire [DEPTH*W-1:0] loadBytes, // byte 0 in low bits
  input wire pop, // host took the head byte
  output wire [W-1:0] headByte, // next result byte
  output wire empty // nothing left to read
);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [3:0] rdPtr_q;
  reg [3:0] cnt_q;
  integer i;
  assign headByte = mem[rdPtr_q];
  assign empty = (cnt_q == 4'h0);
  always @(posedge core_clk) begin
    if (load) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem[i] <= loadBytes[i*W +: W];
      end
    end
  end
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdPtr_q <= 4'h0;
      cnt_q <= 4'h0;
    end else if (load) begin
      rdPtr_q <= 4'h0;
      cnt_q <= loadCount;
    end else if (pop && !empty) begin
      rdPtr_q <= rdPtr_q + 4'h1;
      cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule // fcs_result_queue

// ### fcs_cmd_sequencer.v
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ns
`include "fcs_defines.vh"
module fcs_cmd_sequencer (
  input wire core_clk, // controller clock, 100 MHz
  input wire arst_n, // async reset, active low
  input wire psel, // apb select
  input wire penable, // apb access phase
  input wire pwrite, // apb direction
  input wire [7:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output wire [31:0] prdata, // apb read data
  output wire pready, // apb ready
  output wire pslverr, // unmapped address
  output wire engStart, // one-cycle start of execution
  output wire [7:0] engOpcode, // opcode being executed
  output wire [63:0] engParams, // parameter bytes, byte 0 low
  output wire [7:0] fillPattern, // format data fill byte
  input wire [7:0] diskByte, // byte read from disk
  input wire diskByteValid, // diskByte offered
  output wire diskByteReady, // holding slot is free
  output wire [7:0] fmtIdByte, // id byte for the formatter
  output wire fmtIdValid, // fmtIdByte is pending
  input wire fmtIdTake, // formatter took fmtIdByte
  input wire execDone, // one-cycle end of execution
  input wire [23:0] execStatus, // three status bytes
  input wire [31:0] execChrn, // track, head, sector, size
  output wire drq, // dma request level
  output wire impliedSeekEnable, // configured implied seek
  output wire fifoDisable, // configured fifo off
  output wire pollDisable, // configured polling off
  output wire [3:0] fifoThreshold, // configured threshold
  output wire [7:0] precompStartTrack, // configured track
  output wire [3:0] perpSelect, // per-drive perpendicular
  output wire [1:0] perpGapGate, // gap and write gate bits
  output wire lockState, // lock bit
  output wire [31:0] modeBytes // mode parameters
);
  localparam [4:0] S_IDLE = 5'b00001;
  localparam [4:0] S_PARAM = 5'b00010;
  localparam [4:0] S_DISP = 5'b00100;
  localparam [4:0] S_EXEC = 5'b01000;
  localparam [4:0] S_RES = 5'b10000;

  reg [4:0] state_q;
  reg [7:0] opcode_q;
  reg [10:0] cmd_q;
  reg [3:0] paramIdx_q;
  reg [3:0] paramCnt_q;
  reg [63:0] paramBuf_q;
  reg engStart_q;
  reg [7:0] fillPat_q;
  reg [31:0] prdata_q;
  reg pready_q;
  reg pslverr_q;
  reg ctrlDma_q;
  reg [15:0] timing_q;
  reg [31:0] drvPrecomp_q;
  reg [6:0] cfg_q;
  reg [7:0] startTrk_q;
  reg [3:0] perpDrv_q;
  reg [1:0] perpGw_q;
  reg lock_q;
  reg [31:0] mode_q;
  reg lastWasFmt_q;
  reg [7:0] spt_q;
  reg [7:0] eot_q;
  reg [7:0] dataOut_q;
  reg avail_q;
  reg diskReady_q;
  reg [7:0] fmtByte_q;
  reg fmtFull_q;
  reg [9:0] fmtCnt_q;
  reg drq_q;

  wire [10:0] decCmd;
  wire [3:0] decNp;
  wire [7:0] qHead;
  wire qEmpty;

  wire setup = psel & ~penable;
  wire acc = psel & penable & pready_q;
  wire dataWr = acc & pwrite & (paddr == `FCS_OFF_DATA);
  wire dataRd = acc & ~pwrite & (paddr == `FCS_OFF_DATA);
  wire inExec = state_q[3];
  wire inRes = state_q[4];
  wire isRead = cmd_q[`FCS_CMD_RDAT] | cmd_q[`FCS_CMD_RDEL];
  wire isFmt = cmd_q[`FCS_CMD_FMT];
  wire [9:0] fmtTotal = {spt_q, 2'b00};
  wire fmtRoom = inExec & isFmt & ~fmtFull_q & (fmtCnt_q != fmtTotal);
  wire fmtPush = dataWr & fmtRoom;
  wire diskTake = inExec & isRead & diskByteValid & diskReady_q;
  wire hostTake = dataRd & inExec & isRead & avail_q;
  wire availD = (avail_q | diskTake) & ~hostTake;
  wire fmtFullD = fmtPush | (fmtFull_q & ~fmtIdTake);
  wire [9:0] fmtCntD = fmtPush ? fmtCnt_q + 10'h001 : fmtCnt_q;
  wire [7:0] sptEot = lastWasFmt_q ? spt_q : eot_q;

  fcs_cmd_decode u_dec (
    .opcode(pwdata[7:0]),
    .cmdSel(decCmd),
    .paramCount(decNp)
  );

  // result bytes are built in one place so the queue is loaded in a single cycle
  reg resLoad;
  reg [3:0] resCount;
  reg [79:0] resBytes;
  always @* begin
    resLoad = 1'b0;
    resCount = 4'h0;
    resBytes = 80'h0;
    if (state_q == S_DISP) begin
      if (cmd_q[`FCS_CMD_DUMP]) begin
        resLoad = 1'b1;
        resCount = `FCS_NR_DUMP;
        resBytes = {startTrk_q, 1'b0, cfg_q,
          lock_q, 1'b0, perpDrv_q, perpGw_q,
          sptEot, timing_q[15:8], timing_q[7:0], drvPrecomp_q};
      end else if (cmd_q[`FCS_CMD_LOCK]) begin
        resLoad = 1'b1;
        resCount = `FCS_NR_ONE;
        resBytes = {72'h0, 3'b000, opcode_q[7], 4'b0000};
      end else if (cmd_q[`FCS_CMD_IDENT]) begin
        resLoad = 1'b1;
        resCount = `FCS_NR_ONE;
        resBytes = {72'h0, `FCS_IDENT_BYTE};
      end else if (cmd_q[`FCS_CMD_INV]) begin
        resLoad = 1'b1;
        resCount = `FCS_NR_ONE;
        resBytes = {72'h0, `FCS_INVALID_ST0};
      end
    end else if (inExec && execDone) begin
      resLoad = 1'b1;
      resCount = `FCS_NR_STAT;
      if (isFmt) begin
        resBytes = {56'h0, execStatus};
      end else begin
        resBytes = {24'h0, execChrn, execStatus};
      end
    end
  end

  fcs_result_queue #(
    .DEPTH(10),
    .W(8)
  ) u_res (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .load(resLoad),
    .loadCount(resCount),
    .loadBytes(resBytes),
    .pop(dataRd & inRes),
    .headByte(qHead),
    .empty(qEmpty)
  );

  reg mapped;
  reg [31:0] rdMux;
  always @* begin
    mapped = 1'b1;
    rdMux = 32'h0000_0000;
    case (paddr)
      `FCS_OFF_STAT: begin
        rdMux[`FCS_ST_RQM] = state_q[0] | state_q[1] | (inRes & ~qEmpty) |
          (inExec & isRead & avail_q) | fmtRoom;
        rdMux[`FCS_ST_DIO] = inRes | (inExec & isRead);
        rdMux[`FCS_ST_BUSY] = ~state_q[0];
        rdMux[`FCS_ST_EXEC] = inExec;
        rdMux[`FCS_ST_DRQ] = drq_q;
      end
      `FCS_OFF_DATA: begin
        if (inRes) begin
          rdMux[7:0] = qHead;
        end else if (inExec && isRead && avail_q) begin
          rdMux[7:0] = dataOut_q;
        end
      end
      `FCS_OFF_CTRL: rdMux[0] = ctrlDma_q;
      `FCS_OFF_TIME: rdMux[15:0] = timing_q;
      `FCS_OFF_PRECOMP: rdMux = drvPrecomp_q;
      `FCS_OFF_CFG: rdMux = {startTrk_q, 1'b0, cfg_q, 2'b00, perpDrv_q, perpGw_q, 7'h00, lock_q};
      `FCS_OFF_MODE: rdMux = mode_q;
      default: mapped = 1'b0;
    endcase
  end

  // zero-wait apb: ready rises in the access cycle right after setup
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      ctrlDma_q <= 1'b0;
      timing_q <= 16'h0000;
      drvPrecomp_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      // error stands only beside ready, not until the next setup
      pslverr_q <= setup & ~mapped;
      if (setup) begin
        prdata_q <= pwrite ? 32'h0000_0000 : rdMux;
      end
      if (acc && pwrite) begin
        if (paddr == `FCS_OFF_CTRL) begin
          ctrlDma_q <= pwdata[0];
        end
        if (paddr == `FCS_OFF_TIME) begin
          timing_q <= pwdata[15:0];
        end
        if (paddr == `FCS_OFF_PRECOMP) begin
          drvPrecomp_q <= pwdata;
        end
      end
    end
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= S_IDLE;
      opcode_q <= 8'h00;
      cmd_q <= 11'h000;
      paramIdx_q <= 4'h0;
      paramCnt_q <= 4'h0;
      paramBuf_q <= 64'h0;
      engStart_q <= 1'b0;
      fillPat_q <= 8'h00;
      cfg_q <= 7'h00;
      startTrk_q <= 8'h00;
      perpDrv_q <= 4'h0;
      perpGw_q <= 2'b00;
      lock_q <= 1'b0;
      mode_q <= 32'h0000_0000;
      lastWasFmt_q <= 1'b0;
      spt_q <= 8'h00;
      eot_q <= 8'h00;
    end else begin
      engStart_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (dataWr) begin
            opcode_q <= pwdata[7:0];
            cmd_q <= decCmd;
            paramCnt_q <= decNp;
            paramIdx_q <= 4'h0;
            state_q <= (decNp == 4'h0) ? S_DISP : S_PARAM;
          end
        end
        S_PARAM: begin
          if (dataWr) begin
            paramBuf_q[{paramIdx_q[2:0], 3'b000} +: 8] <= pwdata[7:0];
            paramIdx_q <= paramIdx_q + 4'h1;
            if (paramIdx_q + 4'h1 == paramCnt_q) begin
              state_q <= S_DISP;
            end
          end
        end
        S_DISP: begin
          state_q <= S_RES;
          if (cmd_q[`FCS_CMD_CFG]) begin
            cfg_q <= paramBuf_q[14:8];
            startTrk_q <= paramBuf_q[23:16];
            state_q <= S_IDLE;
          end
          if (cmd_q[`FCS_CMD_MODE]) begin
            mode_q <= paramBuf_q[31:0];
            state_q <= S_IDLE;
          end
          if (cmd_q[`FCS_CMD_PERP]) begin
            perpGw_q <= paramBuf_q[1:0];
            if (paramBuf_q[7]) begin
              perpDrv_q <= paramBuf_q[5:2];
            end
            state_q <= S_IDLE;
          end
          if (cmd_q[`FCS_CMD_LOCK]) begin
            lock_q <= opcode_q[7];
          end
          if (isFmt) begin
            spt_q <= paramBuf_q[23:16];
            fillPat_q <= paramBuf_q[39:32];
            lastWasFmt_q <= 1'b1;
          end
          if (isRead) begin
            eot_q <= paramBuf_q[47:40];
            lastWasFmt_q <= 1'b0;
          end
          if (isFmt || isRead || cmd_q[`FCS_CMD_RDID]) begin
            engStart_q <= 1'b1;
            state_q <= S_EXEC;
          end
        end
        S_EXEC: begin
          if (execDone) begin
            state_q <= S_RES;
          end
        end
        S_RES: begin
          if (qEmpty) begin
            state_q <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // execution data: one holding byte each way, so each side stalls the other
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dataOut_q <= 8'h00;
      avail_q <= 1'b0;
      diskReady_q <= 1'b0;
      fmtByte_q <= 8'h00;
      fmtFull_q <= 1'b0;
      fmtCnt_q <= 10'h000;
      drq_q <= 1'b0;
    end else begin
      if (diskTake) begin
        dataOut_q <= diskByte;
      end
      if (engStart_q) begin
        avail_q <= 1'b0;
        fmtFull_q <= 1'b0;
        fmtCnt_q <= 10'h000;
      end else begin
        avail_q <= availD;
        fmtFull_q <= fmtFullD;
        fmtCnt_q <= fmtCntD;
      end
      if (fmtPush) begin
        fmtByte_q <= pwdata[7:0];
      end
      diskReady_q <= inExec & isRead & ~availD & ~execDone;
      drq_q <= ctrlDma_q & inExec & ~execDone & ((isRead & availD) |
        (isFmt & ~fmtFullD & (fmtCntD != fmtTotal)));
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign engStart = engStart_q;
  assign engOpcode = opcode_q;
  assign engParams = paramBuf_q;
  assign fillPattern = fillPat_q;
  assign diskByteReady = diskReady_q;
  assign fmtIdByte = fmtByte_q;
  assign fmtIdValid = fmtFull_q;
  assign drq = drq_q;
  assign impliedSeekEnable = cfg_q[6];
  assign fifoDisable = cfg_q[5];
  assign pollDisable = cfg_q[4];
  assign fifoThreshold = cfg_q[3:0];
  assign precompStartTrack = startTrk_q;
  assign perpSelect = perpDrv_q;
  assign perpGapGate = perpGw_q;
  assign lockState = lock_q;
  assign modeBytes = mode_q;
endmodule // fcs_cmd_sequencer

// ### fcs_asserts.sv
`timescale 1ns/1ns
module fcs_asserts (
  input wire logic core_clk, // clock
  input wire logic arst_n, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb address
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic engStart, // execution start
  input wire logic diskByteValid, // disk byte offered
  input wire logic diskByteReady, // slot free
  input wire logic [7:0] fmtIdByte, // id byte
  input wire logic fmtIdValid, // id byte pending
  input wire logic fmtIdTake, // id byte taken
  input wire logic impliedSeekEnable, // config
  input wire logic fifoDisable, // config
  input wire logic pollDisable, // config
  input wire logic [3:0] fifoThreshold, // config
  input wire logic [7:0] precompStartTrack, // config
  input wire logic [3:0] perpSelect, // perpendicular drives
  input wire logic [1:0] perpGapGate, // gap and write gate
  input wire logic lockState, // lock
  input wire logic [31:0] modeBytes // mode
);
  logic [3:0] wrHist_q;
  // settings may only move a few cycles after a data port write
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) wrHist_q <= 4'h0;
    else wrHist_q <= {wrHist_q[2:0], psel && penable && pwrite && paddr == 8'h04};
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_rd_done;
    psel && penable && pready && !pwrite;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_with_ready: assert property (pslverr |-> pready && psel && penable)
    else $error("error outside access");
  a_unmapped_reads_zero: assert property (s_rd_done ##0 pslverr |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_start_one_pulse: assert property (engStart |=> !engStart)
    else $error("start pulse too long");
  a_disk_slot_fills: assert property (diskByteValid && diskByteReady |=> !diskByteReady)
    else $error("slot not filled");
  a_id_held_until_take: assert property (fmtIdValid && !fmtIdTake |=> fmtIdValid && $stable(fmtIdByte))
    else $error("id byte dropped");
  a_regs_from_write: assert property (!$stable({impliedSeekEnable, fifoDisable, pollDisable, fifoThreshold,
    precompStartTrack, perpSelect, perpGapGate, lockState, modeBytes}) |-> |wrHist_q)
    else $error("setting changed without command");
endmodule // fcs_asserts
bind fcs_cmd_sequencer fcs_asserts fcs_asserts_i (.core_clk, .arst_n, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .engStart, .diskByteValid, .diskByteReady, .fmtIdByte, .fmtIdValid,
  .fmtIdTake, .impliedSeekEnable, .fifoDisable, .pollDisable, .fifoThreshold, .precompStartTrack,
  .perpSelect, .perpGapGate, .lockState, .modeBytes);

// ### fcs_disk_engine.sv
`timescale 1ns/1ns
module fcs_disk_engine #(
  parameter logic [7:0] NRD = 8'h03, // bytes per read
  parameter logic [31:0] HDR = 32'h0211_0507 // header met by read id
) (
  input wire logic core_clk, // clock
  input wire logic arst_n, // async reset, active low
  input wire logic engStart, // execution start
  input wire logic [7:0] engOpcode, // opcode
  input wire logic [63:0] engParams, // parameters
  input wire logic diskByteReady, // slot free
  input wire logic fmtIdValid, // id byte pending
  output logic [7:0] diskByte, // disk byte
  output logic diskByteValid, // byte offered
  output logic fmtIdTake, // id byte consumed
  output logic execDone, // end of execution
  output logic [23:0] execStatus, // three status bytes
  output logic [31:0] execChrn // track head sector size
);
  localparam logic [23:0] ST = 24'h03_0201;
  logic busy_q, rd_q, fmt_q;
  logic [7:0] cnt_q, last_q, ids;
  logic [31:0] chrn_q;
  // four id bytes per sector, sectors per track is the third parameter
  assign ids = {engParams[21:16], 2'b00};
  assign diskByteValid = busy_q && rd_q && cnt_q < NRD;
  // released lines never repeat their last value
  assign diskByte = diskByteValid ? 8'hA0 + cnt_q : ~last_q;
  assign execStatus = execDone ? ST : ~ST;
  assign execChrn = execDone ? chrn_q : ~chrn_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      {busy_q, rd_q, fmt_q, fmtIdTake, execDone} <= 5'h00;
      {cnt_q, last_q} <= 16'h0000;
      chrn_q <= 32'h0000_0000;
    end else begin
      fmtIdTake <= 1'b0;
      execDone <= 1'b0;
      if (engStart) begin
        busy_q <= 1'b1;
        cnt_q <= 8'h00;
        rd_q <= engOpcode[4:0] == 5'h06 || engOpcode[4:0] == 5'h0C;
        fmt_q <= {engOpcode[7], engOpcode[5:0]} == 7'h0D;
        chrn_q <= {engOpcode[7], engOpcode[5:0]} == 7'h0A ? HDR : engParams[39:8];
      end else if (busy_q) begin
        if (diskByteValid && diskByteReady) begin
          cnt_q <= cnt_q + 8'h01;
          last_q <= diskByte;
        end
        if (fmt_q && fmtIdValid && !fmtIdTake && cnt_q < ids) begin
          fmtIdTake <= 1'b1;
          cnt_q <= cnt_q + 8'h01;
        end
        if (rd_q ? cnt_q == NRD && diskByteReady : !fmt_q || (cnt_q == ids && !fmtIdValid && !fmtIdTake)) begin
          busy_q <= 1'b0;
          execDone <= 1'b1;
        end
      end
    end
  end
endmodule // fcs_disk_engine

// ### tb_top.sv
`timescale 1ns/1ns
`include "fcs_defines.vh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
  logic core_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, slvErr;
  logic [7:0] paddr = 8'h00, idLast, engOpcode, fillPattern, diskByte, fmtIdByte, precompStartTrack;
  logic [31:0] pwdata = 32'h0000_0000, rdv, prdata, execChrn, modeBytes;
  logic pready, pslverr, engStart, diskByteValid, diskByteReady, fmtIdValid, fmtIdTake, execDone, drq;
  logic impliedSeekEnable, fifoDisable, pollDisable, lockState;
  logic [63:0] engParams;
  logic [23:0] execStatus;
  logic [3:0] fifoThreshold, perpSelect;
  logic [1:0] perpGapGate;
  int err_total = 0, cmp_count = 0, idCnt = 0;
  fcs_cmd_sequencer fcs_cmd_sequencer_i (.core_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .engStart, .engOpcode, .engParams, .fillPattern, .diskByte, .diskByteValid,
    .diskByteReady, .fmtIdByte, .fmtIdValid, .fmtIdTake, .execDone, .execStatus, .execChrn, .drq,
    .impliedSeekEnable, .fifoDisable, .pollDisable, .fifoThreshold, .precompStartTrack, .perpSelect,
    .perpGapGate, .lockState, .modeBytes);
  fcs_disk_engine fcs_disk_engine_i (.core_clk, .arst_n, .engStart, .engOpcode, .engParams, .diskByteReady,
    .fmtIdValid, .diskByte, .diskByteValid, .fmtIdTake, .execDone, .execStatus, .execChrn);
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (fmtIdValid && fmtIdTake) begin
      idCnt <= idCnt + 1;
      idLast <= fmtIdByte;
    end
  end
  task automatic complete_run();
    $display("comparisons %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic hang();
    err_total++;
    $display("[ERR] t=%0t wait ran out %h %h", $time, 1'b0, 1'b1);
    complete_run();
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) hang();
    rdv = prdata;
    slvErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic poll(input logic [7:0] m, input logic [7:0] v);
    int n = 0;
    do begin
      apb(1'b0, `FCS_OFF_STAT, '0);
      n++;
    end while ((rdv[7:0] & m) !== v && n < 200);
    if (n >= 200) hang();
  endtask
  task automatic cmd(input logic [7:0] q[$]);
    foreach (q[i]) begin
      poll(8'h03, 8'h01);
      apb(1'b1, `FCS_OFF_DATA, {24'h00_0000, q[i]});
    end
  endtask
  task automatic res(input logic [7:0] q[$]);
    foreach (q[i]) begin
      poll(8'h03, 8'h03);
      apb(1'b0, `FCS_OFF_DATA, '0);
      `CHK(rdv[7:0], q[i])
    end
  endtask
  task automatic dump(input logic [7:0] b6);
    cmd('{`FCS_OPC_DUMP});
    res('{8'h11, 8'h22, 8'h33, 8'h44, 8'h12, 8'h34, b6, 8'h3C, 8'h57, 8'h21});
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    apb(1'b0, `FCS_OFF_CTRL, '0);
    `CHK(rdv, 32'h0000_0000)
    apb(1'b0, 8'h40, '0);
    `CHK({slvErr, rdv}, 33'h0_0000_0000 | 33'h1_0000_0000)
    apb(1'b1, `FCS_OFF_TIME, 32'h0000_3412);
    apb(1'b1, `FCS_OFF_PRECOMP, 32'h4433_2211);
    apb(1'b1, `FCS_OFF_STAT, 32'hFFFF_FFFF);
    apb(1'b0, `FCS_OFF_STAT, '0);
    `CHK(rdv, 32'h0000_0001)
    cmd('{`FCS_OPC_CFG, 8'h00, 8'h57, 8'h21});
    poll(8'h03, 8'h01);
    `CHK({impliedSeekEnable, fifoDisable, pollDisable, fifoThreshold}, 7'h57)
    `CHK(precompStartTrack, 8'h21)
    cmd('{`FCS_OPC_PERP, 8'hBF});
    cmd('{`FCS_OPC_PERP, 8'h14});
    poll(8'h03, 8'h01);
    `CHK({perpSelect, perpGapGate}, 6'h3C)
    cmd('{`FCS_OPC_MODE, 8'h11, 8'h22, 8'h33, 8'h44});
    poll(8'h03, 8'h01);
    `CHK(modeBytes, 32'h4433_2211)
    cmd('{8'h94});
    res('{8'h10});
    `CHK(lockState, 1'b1)
    cmd('{8'h14});
    res('{8'h00});
    cmd('{`FCS_OPC_IDENT});
    res('{8'h5A});
    cmd('{8'h1F});
    poll(8'h03, 8'h03);
    `CHK(rdv[7:0], 8'h07)
    res('{8'h80});
    dump(8'h00);
    cmd('{8'h4D, 8'h01, 8'h02, 8'h02, 8'h1B, 8'hE5});
    for (int s = 1; s < 3; s++) cmd('{8'h05, 8'h01, s[7:0], 8'h02});
    `CHK({fillPattern, engOpcode, engParams[39:0]}, 56'hE5_4DE5_1B02_0201)
    res('{8'h01, 8'h02, 8'h03});
    repeat (4) begin
      poll(8'h03, 8'h03);
      apb(1'b0, `FCS_OFF_DATA, '0);
    end
    `CHK({idCnt[7:0], idLast}, 16'h0802)
    dump(8'h02);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, `FCS_OFF_CTRL, {31'h0000_0000, k[0]});
      cmd('{k ? 8'h4C : 8'h46, 8'h01, 8'h05, 8'h01, 8'h03, 8'h02, 8'h09, 8'h1B, 8'hFF});
      for (int j = 0; j < 3; j++) begin
        if (k == 0) poll(8'h0B, 8'h0B);
        for (int n = 0; k == 1 && drq !== 1'b1; n++) begin
          if (n > 200) hang();
          @(posedge core_clk);
        end
        apb(1'b0, `FCS_OFF_DATA, '0);
        `CHK(rdv[7:0], 8'hA0 + j[7:0])
      end
      res('{8'h01, 8'h02, 8'h03, 8'h05, 8'h01, 8'h03, 8'h02});
    end
    dump(8'h09);
    cmd('{8'h4A, 8'h01});
    res('{8'h01, 8'h02, 8'h03, 8'h07, 8'h05, 8'h11, 8'h02});
    complete_run();
  end
endmodule // tb_top
